// ### design/piw_pkg.sv
// Contract
// - ten request sources feed the controller
// - per-source enable; disabled source never presented
// - global enable clear blocks every source
// - two priority bits per source, four levels
// - preempt active service only for higher level
// - topmost-level service is never interrupted
// - highest pending level wins at instruction start
// - fixed polling order breaks ties within level
// - enabled keypad request wakes idle or power-down
// - idle ends on any enabled request
// - power-down ends on wake-capable subset request
// - brownout resets by default, optionally interrupts
package piw_pkg;
  // source count and widths
  localparam int NSRC     = 10;
  localparam int SRC_W    = 4;
  localparam int LVL_W    = 2;
  localparam int NLVL     = 4;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 8;
  // source indices in listed order
  localparam int SRC_BOD  = 5;
  localparam int SRC_KBD  = 7;
  // register offsets
  localparam logic [3:0] OFS_EN_A    = 4'h0;
  localparam logic [3:0] OFS_EN_B    = 4'h1;
  localparam logic [3:0] OFS_PLO_A   = 4'h2;
  localparam logic [3:0] OFS_PHI_A   = 4'h3;
  localparam logic [3:0] OFS_PLO_B   = 4'h4;
  localparam logic [3:0] OFS_PHI_B   = 4'h5;
  localparam logic [3:0] OFS_CTRL    = 4'h6;
  localparam logic [3:0] OFS_SERVICE = 4'h7;
  localparam logic [3:0] OFS_STAT    = 4'h8;
  localparam logic [3:0] OFS_MASK    = 4'h9;
  // field positions
  localparam int EN_GLOBAL_BIT = 7;
  localparam int REG_A_SRCS    = 7;
  localparam int CTRL_BOD_IRQ  = 0;
  localparam int ST_ACK        = 0;
  localparam int ST_WAKE       = 1;
  localparam int ST_PREEMPT    = 2;
  localparam int ST_W          = 3;
  // reset values
  localparam logic [7:0] RST_EN   = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [2:0] RST_STAT = 3'h0;
  localparam logic [2:0] RST_MASK = 3'h0;
  // sources able to end power-down: bod, wdt/rtc, keypad, comparators
  localparam logic [9:0] WAKE_PD_SET = 10'h1e0;
  // vector request toward the core
  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] src;
    logic [LVL_W-1:0] level;
  } piw_req_t;
endpackage : piw_pkg

// ### design/piw_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module piw_ctrl #(
  parameter int         NSRC     = piw_pkg::NSRC,       // request sources
  parameter logic [9:0] WAKE_SET = piw_pkg::WAKE_PD_SET  // power-down wake sources
) (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // register port
  input  wire logic [piw_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [piw_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_we,
  input  wire logic                        reg_re,
  output logic      [piw_pkg::DATA_W-1:0] reg_rdata,
  // peripheral requests, levels
  input  wire logic [NSRC-1:0]             src_req,
  // core side
  input  wire logic                        inst_start,
  input  wire logic                        vec_ack,
  input  wire logic                        reti,
  input  wire logic                        core_idle,
  input  wire logic                        core_pd,
  output piw_pkg::piw_req_t                core_req,
  output logic                             wake,
  output logic                             bod_reset_req,
  output logic                             irq
);

  // enable, priority and control registers
  logic [7:0]               en_a_q;        // global bit and sources 0..6
  logic [7:0]               en_b_q;        // sources 7..9
  logic [7:0]               plo_a_q;       // priority low bits, first group
  logic [7:0]               phi_a_q;       // priority high bits, first group
  logic [7:0]               plo_b_q;       // priority low bits, second group
  logic [7:0]               phi_b_q;       // priority high bits, second group
  logic [7:0]               ctrl_q;        // brownout routing
  logic [piw_pkg::ST_W-1:0] stat_q;        // sticky events
  logic [piw_pkg::ST_W-1:0] stat_d;
  logic [piw_pkg::ST_W-1:0] mask_q;        // event mask
  logic [piw_pkg::NLVL-1:0] isr_q;         // in-service per level
  logic [piw_pkg::NLVL-1:0] isr_d;
  piw_pkg::piw_req_t        req_q;         // presented vector
  piw_pkg::piw_req_t        req_d;
  logic                     wake_q;        // registered wake
  logic [7:0]               rdata_q;       // read data, one cycle later

  // per-source flattened views
  logic [NSRC-1:0]               en_vec;   // individual enables
  logic [NSRC-1:0]               plo_vec;  // priority low bits
  logic [NSRC-1:0]               phi_vec;  // priority high bits
  logic [NSRC-1:0]               req_vec;  // requests after brownout routing
  logic [NSRC-1:0]               elig;     // enabled and requesting
  logic [piw_pkg::LVL_W-1:0]     lvl [NSRC];

  // register decode
  wire global_en = en_a_q[piw_pkg::EN_GLOBAL_BIT];
  wire bod_irq   = ctrl_q[piw_pkg::CTRL_BOD_IRQ];
  wire wr_en_a   = reg_we && (reg_addr == piw_pkg::OFS_EN_A);
  wire wr_en_b   = reg_we && (reg_addr == piw_pkg::OFS_EN_B);
  wire wr_plo_a  = reg_we && (reg_addr == piw_pkg::OFS_PLO_A);
  wire wr_phi_a  = reg_we && (reg_addr == piw_pkg::OFS_PHI_A);
  wire wr_plo_b  = reg_we && (reg_addr == piw_pkg::OFS_PLO_B);
  wire wr_phi_b  = reg_we && (reg_addr == piw_pkg::OFS_PHI_B);
  wire wr_ctrl   = reg_we && (reg_addr == piw_pkg::OFS_CTRL);
  wire wr_stat   = reg_we && (reg_addr == piw_pkg::OFS_STAT);
  wire wr_mask   = reg_we && (reg_addr == piw_pkg::OFS_MASK);

  assign en_vec  = {en_b_q[2:0], en_a_q[piw_pkg::REG_A_SRCS-1:0]};
  assign plo_vec = {plo_b_q[2:0], plo_a_q[piw_pkg::REG_A_SRCS-1:0]};
  assign phi_vec = {phi_b_q[2:0], phi_a_q[piw_pkg::REG_A_SRCS-1:0]};

  // per-source gating and level
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_src
      // brownout reaches the arbiter only when routed to interrupt
      if (gi == piw_pkg::SRC_BOD) begin : g_bod
        assign req_vec[gi] = src_req[gi] && bod_irq;
      end else begin : g_plain
        assign req_vec[gi] = src_req[gi];
      end
      assign elig[gi] = req_vec[gi] && en_vec[gi] && global_en;
      assign lvl[gi]  = {phi_vec[gi], plo_vec[gi]};
    end
  endgenerate

  // default brownout action is a reset request
  assign bod_reset_req = src_req[piw_pkg::SRC_BOD] && !bod_irq;

  // highest level, lowest index on ties
  logic                      best_valid;
  logic [piw_pkg::SRC_W-1:0] best_src;
  logic [piw_pkg::LVL_W-1:0] best_lvl;
  always_comb begin
    best_valid = 1'b0;
    best_src   = '0;
    best_lvl   = '0;
    // scan from the last source so earlier ones win equal levels
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (elig[i] && (!best_valid || lvl[i] >= best_lvl)) begin
        best_valid = 1'b1;
        best_src   = piw_pkg::SRC_W'(i);
        best_lvl   = lvl[i];
      end
    end
  end

  // current service level: highest in-service flag
  wire                      any_isr = |isr_q;
  wire [piw_pkg::LVL_W-1:0] cur_lvl = isr_q[3] ? 2'h3 : isr_q[2] ? 2'h2 : isr_q[1] ? 2'h1 : 2'h0;
  // strictly higher only; level three can never be exceeded
  wire grant = best_valid && (!any_isr || best_lvl > cur_lvl);

  // highest in-service flag, cleared on return
  wire [piw_pkg::NLVL-1:0] isr_top = isr_q[3] ? 4'h8 : isr_q[2] ? 4'h4 : isr_q[1] ? 4'h2 : isr_q[0] ? 4'h1 : 4'h0;
  wire [piw_pkg::NLVL-1:0] isr_set = vec_ack && req_q.valid ? (4'h1 << req_q.level) : 4'h0;
  assign isr_d = (isr_q & ~(reti ? isr_top : 4'h0)) | isr_set;

  // vector: sampled at instruction start, dropped on acknowledge
  always_comb begin
    req_d = req_q;
    if (vec_ack) begin
      req_d.valid = 1'b0;
    end else if (inst_start) begin
      req_d.valid = grant;
      req_d.src   = best_src;
      req_d.level = best_lvl;
    end
  end

  // wake: any enabled request in idle, subset in power-down
  wire any_elig = |elig;
  wire pd_elig  = |(elig & WAKE_SET[NSRC-1:0]);
  wire wake_d   = (core_idle && any_elig) || (core_pd && pd_elig);

  // sticky events, set wins over write-one clear
  wire [piw_pkg::ST_W-1:0] ev = {vec_ack && req_q.valid && any_isr, wake_d && !wake_q,
                                 vec_ack && req_q.valid};
  assign stat_d = (stat_q & ~(wr_stat ? reg_wdata[piw_pkg::ST_W-1:0] : '0)) | ev;

  // read mux
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      piw_pkg::OFS_EN_A:    rd_mux = en_a_q;
      piw_pkg::OFS_EN_B:    rd_mux = en_b_q;
      piw_pkg::OFS_PLO_A:   rd_mux = plo_a_q;
      piw_pkg::OFS_PHI_A:   rd_mux = phi_a_q;
      piw_pkg::OFS_PLO_B:   rd_mux = plo_b_q;
      piw_pkg::OFS_PHI_B:   rd_mux = phi_b_q;
      piw_pkg::OFS_CTRL:    rd_mux = ctrl_q;
      piw_pkg::OFS_SERVICE: rd_mux = {req_q.valid, 3'h0, isr_q};
      piw_pkg::OFS_STAT:    rd_mux = {5'h00, stat_q};
      piw_pkg::OFS_MASK:    rd_mux = {5'h00, mask_q};
      default:              rd_mux = 8'h00;   // unmapped reads zero
    endcase
  end

  // configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_a_q  <= piw_pkg::RST_EN;
      en_b_q  <= piw_pkg::RST_EN;
      plo_a_q <= piw_pkg::RST_PRIO;
      phi_a_q <= piw_pkg::RST_PRIO;
      plo_b_q <= piw_pkg::RST_PRIO;
      phi_b_q <= piw_pkg::RST_PRIO;
      ctrl_q  <= piw_pkg::RST_CTRL;
      mask_q  <= piw_pkg::RST_MASK;
    end else begin
      if (wr_en_a)  en_a_q  <= reg_wdata;
      if (wr_en_b)  en_b_q  <= {5'h00, reg_wdata[2:0]};
      if (wr_plo_a) plo_a_q <= {1'b0, reg_wdata[6:0]};
      if (wr_phi_a) phi_a_q <= {1'b0, reg_wdata[6:0]};
      if (wr_plo_b) plo_b_q <= {5'h00, reg_wdata[2:0]};
      if (wr_phi_b) phi_b_q <= {5'h00, reg_wdata[2:0]};
      if (wr_ctrl)  ctrl_q  <= {7'h00, reg_wdata[0]};
      if (wr_mask)  mask_q  <= reg_wdata[piw_pkg::ST_W-1:0];
    end
  end

  // arbitration state, status and read data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      isr_q   <= '0;
      req_q   <= '0;
      wake_q  <= 1'b0;
      stat_q  <= piw_pkg::RST_STAT;
      rdata_q <= 8'h00;
    end else begin
      isr_q   <= isr_d;
      req_q   <= req_d;
      wake_q  <= wake_d;
      stat_q  <= stat_d;
      rdata_q <= reg_re ? rd_mux : 8'h00;
    end
  end

  assign core_req  = req_q;
  assign wake      = wake_q;
  assign reg_rdata = rdata_q;
  assign irq       = |(stat_q & mask_q);

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // sampling step at an instruction start without acknowledge
  sequence s_sample;
    inst_start && !vec_ack;
  endsequence
  // acknowledge of a presented vector
  sequence s_ack;
    vec_ack && req_q.valid && !reti;
  endsequence
  // return from a routine with no acknowledge beside it
  sequence s_ret;
    reti && !vec_ack;
  endsequence

  // check helpers against the selection staged for the next edge, except chk_above_cur, which uses the running service
  logic [NSRC-1:0] chk_above_sel;   // eligible above the staged level
  logic [NSRC-1:0] chk_tie_before;  // eligible at the staged level, lower index
  logic [NSRC-1:0] chk_above_cur;   // eligible above the running service
  logic [NSRC-1:0] chk_sel_hot;     // staged source, eligible at its level
  logic            chk_sel_en;      // staged source enabled, global bit set
  genvar ci;
  generate
    for (ci = 0; ci < NSRC; ci++) begin : g_chk
      assign chk_above_sel[ci]  = elig[ci] && (lvl[ci] > req_d.level);
      assign chk_tie_before[ci] = elig[ci] && (lvl[ci] == req_d.level) && (piw_pkg::SRC_W'(ci) < req_d.src);
      assign chk_above_cur[ci]  = elig[ci] && (lvl[ci] > cur_lvl);
      assign chk_sel_hot[ci]    = elig[ci] && (lvl[ci] == req_d.level) && (piw_pkg::SRC_W'(ci) == req_d.src);
    end
  endgenerate
  assign chk_sel_en = en_vec[req_d.src] && global_en;

  // a presented source had its own enable and the global bit
  a_disabled_not_sent: assert property (
    s_sample ##1 req_q.valid |-> $past(chk_sel_en))
    else $error("disabled source presented");

  // global enable clear keeps the vector down
  a_global_off_quiet: assert property (
    (s_sample and !global_en) |=> !req_q.valid)
    else $error("request presented with global enable clear");

  // equal or lower level waits behind a running routine
  a_preempt_higher: assert property (
    (s_sample and any_isr && chk_above_cur == '0) |=> !req_q.valid)
    else $error("equal or lower level preempted service");

  // nothing gets past a routine at the top level
  a_top_never_pre: assert property (
    (s_sample and isr_q[3]) |=> !req_q.valid)
    else $error("top level service interrupted");

  // selection is eligible and nothing eligible stands above it
  a_highest_chosen: assert property (
    s_sample ##1 req_q.valid |-> $past(chk_above_sel) == '0 && $past(chk_sel_hot) != '0)
    else $error("selected level not highest");

  // first source at the top level wins its tie
  a_tie_first_wins: assert property (
    (s_sample and elig[0] && !any_isr && lvl[0] == 2'h3) |=> req_q.valid && req_q.src == 4'h0)
    else $error("tie not won by first source");

  // no lower index at the chosen level was passed over
  a_tie_lowest: assert property (
    s_sample ##1 req_q.valid |-> $past(chk_tie_before) == '0)
    else $error("tie won by a later source");

  // a free core always gets an eligible request
  a_grant_when_free: assert property (
    (s_sample and !any_isr && elig != '0) |=> req_q.valid)
    else $error("eligible request not presented");

  // a strictly higher request preempts the running routine
  a_higher_preempts: assert property (
    (s_sample and any_isr && chk_above_cur != '0) |=> req_q.valid)
    else $error("higher level did not preempt");

  // vector stands between boundaries and acknowledges
  a_vector_stands: assert property (
    (!inst_start && !vec_ack) |=> $stable(req_q))
    else $error("vector changed between boundaries");

  // any enabled request ends idle
  a_idle_wakes: assert property (
    (core_idle && any_elig) |=> wake)
    else $error("idle not ended by enabled request");

  // a running core sees no wake
  a_awake_quiet: assert property (
    (!core_idle && !core_pd) |=> !wake)
    else $error("wake raised while running");

  // only the wake subset ends power-down
  a_pd_subset: assert property (
    (core_pd && !core_idle && !pd_elig) |=> !wake)
    else $error("power-down woken by non wake source");

  // a wake-capable request ends power-down
  a_pd_wakes: assert property (
    (core_pd && pd_elig) |=> wake)
    else $error("power-down not ended by wake source");

  // enabled keypad ends either low-power mode
  a_kbd_wakes: assert property (
    ((core_idle || core_pd) && elig[piw_pkg::SRC_KBD]) |=> wake)
    else $error("keypad did not wake the core");

  // global enable clear also blocks wake
  a_global_no_wake: assert property (
    !global_en |=> !wake)
    else $error("wake with global enable clear");

  // brownout default goes to reset
  a_bod_route: assert property (
    (src_req[piw_pkg::SRC_BOD] && !bod_irq) |-> bod_reset_req && !req_vec[piw_pkg::SRC_BOD])
    else $error("brownout not routed to reset");

  // routed brownout never asks for reset
  a_bod_no_reset: assert property (
    bod_irq |-> !bod_reset_req)
    else $error("routed brownout requested reset");

  // acknowledge sets the level flag and drops the vector
  a_isr_on_ack: assert property (
    s_ack |=> isr_q[$past(req_q.level)] && !req_q.valid)
    else $error("in-service flag not set on acknowledge");

  // return clears the top flag and leaves the rest
  a_isr_ret: assert property (
    (reti && !vec_ack && isr_q[3]) |=> !isr_q[3] && isr_q[2:0] == $past(isr_q[2:0]))
    else $error("return did not clear highest flag only");

  // any return drops exactly one flag and adds none
  a_ret_one_flag: assert property (
    (s_ret and any_isr) |=> ($countones(isr_q) + 1 == $countones($past(isr_q))) && (isr_q & ~$past(isr_q)) == '0)
    else $error("return did not clear exactly one flag");

endmodule : piw_ctrl
`default_nettype wire

// ### sim/piw_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// core side: boundaries, vector takes and returns on command
module piw_core_model (
  input  wire logic              clk,        // core clock
  input  wire piw_pkg::piw_req_t core_req,   // offered vector
  output logic                   inst_start, // boundary pulse
  output logic                   vec_ack,    // take pulse
  output logic                   reti        // return pulse
);
  // quiet core until told otherwise
  initial begin
    inst_start = 1'b0;
    vec_ack    = 1'b0;
    reti       = 1'b0;
  end
  // one instruction boundary
  task automatic boundary();
    @(posedge clk);
    inst_start <= 1'b1;
    @(posedge clk);
    inst_start <= 1'b0;
  endtask : boundary
  // take the offered vector after lag plus one edges, only if one is offered
  task automatic take(input int lag);
    repeat (lag) @(posedge clk);
    @(posedge clk);
    vec_ack <= core_req.valid;
    @(posedge clk);
    vec_ack <= 1'b0;
  endtask : take
  // leave the running service routine
  task automatic ret();
    @(posedge clk);
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
  endtask : ret
endmodule : piw_core_model
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                       clk;           // 250 mhz clock
  logic                       arst_n;        // async reset
  logic [piw_pkg::ADDR_W-1:0] reg_addr;      // register index
  logic [piw_pkg::DATA_W-1:0] reg_wdata;     // write data
  logic                       reg_we;        // write strobe
  logic                       reg_re;        // read strobe
  logic [piw_pkg::DATA_W-1:0] reg_rdata;     // read data
  logic [9:0]                 src_req;       // peripheral requests
  logic                       core_idle;     // core idle level
  logic                       core_pd;       // core power-down level
  logic                       inst_start;    // from core model
  logic                       vec_ack;       // from core model
  logic                       reti;          // from core model
  piw_pkg::piw_req_t          core_req;      // vector request
  logic                       wake;          // wake level
  logic                       bod_reset_req; // brownout reset request
  logic                       irq;           // interrupt line
  int                         n_mismatch;    // mismatches seen
  int                         n_checks;      // compares made
  logic [1:0]                 lv [10];       // level per source
  // clock
  initial clk = 1'b0;
  always #2 clk = ~clk;
  piw_ctrl DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .src_req(src_req), .inst_start(inst_start), .vec_ack(vec_ack),
    .reti(reti), .core_idle(core_idle), .core_pd(core_pd), .core_req(core_req), .wake(wake),
    .bod_reset_req(bod_reset_req), .irq(irq));
  piw_core_model core (.clk(clk), .core_req(core_req), .inst_start(inst_start), .vec_ack(vec_ack), .reti(reti));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: seen %h exp %h", $time, m, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // one-cycle write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
    #1;
  endtask : wr
  // one-cycle read, data looked at in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk(reg_rdata, e, m);
  endtask : rd
  // enables: global bit plus one bit per source
  task automatic set_en(input logic g, input logic [9:0] en);
    wr(piw_pkg::OFS_EN_A, {g, en[6:0]});
    wr(piw_pkg::OFS_EN_B, {5'h00, en[9:7]});
  endtask : set_en
  // levels from lv, split into low and high bit registers
  task automatic set_prio();
    logic [9:0] lo;
    logic [9:0] hi;
    for (int i = 0; i < 10; i++) begin
      lo[i] = lv[i][0];
      hi[i] = lv[i][1];
    end
    wr(piw_pkg::OFS_PLO_A, {1'b0, lo[6:0]});
    wr(piw_pkg::OFS_PHI_A, {1'b0, hi[6:0]});
    wr(piw_pkg::OFS_PLO_B, {5'h00, lo[9:7]});
    wr(piw_pkg::OFS_PHI_B, {5'h00, hi[9:7]});
  endtask : set_prio
  // raise requests, pass a boundary, look at the offered vector
  task automatic grant(input logic [9:0] req, input logic v, input logic [3:0] s, input logic [1:0] l);
    @(posedge clk);
    src_req <= req;
    core.boundary();
    #1;
    chk(v ? {1'b0, core_req} : {7'h00, core_req.valid}, v ? {1'b0, 1'b1, s, l} : 8'h00, "vector");
  endtask : grant
  // wait n edges then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  // main sequence
  initial begin
    arst_n = 1'b0; reg_addr = '0; reg_wdata = '0; reg_we = 1'b0; reg_re = 1'b0;
    src_req = '0; core_idle = 1'b0; core_pd = 1'b0; n_mismatch = 0; n_checks = 0;
    for (int i = 0; i < 10; i++) lv[i] = 2'h0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    // reset values and an unmapped place
    for (int a = 0; a < 11; a++) rd(a[3:0], 8'h00, "reset value");
    wr(4'ha, 8'hff);
    rd(4'ha, 8'h00, "unmapped");
    // global and per-source enables
    set_en(1'b0, 10'h3ff);
    grant(10'h002, 1'b0, 4'h0, 2'h0);
    set_en(1'b1, 10'h3fd);
    grant(10'h002, 1'b0, 4'h0, 2'h0);
    set_en(1'b1, 10'h3ff);
    // every source alone; brownout goes to reset by default
    for (int i = 0; i < 10; i++) begin
      grant(10'h001 << i, i != 5, i[3:0], 2'h0);
      chk({7'h00, bod_reset_req}, {7'h00, i == 5}, "brownout reset");
    end
    wr(piw_pkg::OFS_CTRL, 8'h01);
    grant(10'h020, 1'b1, 4'h5, 2'h0);
    chk({7'h00, bod_reset_req}, 8'h00, "brownout routed");
    // levels and ties
    lv[0] = 2'h1; lv[3] = 2'h2; lv[6] = 2'h2; lv[8] = 2'h3; lv[9] = 2'h3;
    set_prio();
    rd(piw_pkg::OFS_PHI_A, 8'h48, "high bits a");
    rd(piw_pkg::OFS_PLO_B, 8'h06, "low bits b");
    grant(10'h009, 1'b1, 4'h3, 2'h2);
    grant(10'h048, 1'b1, 4'h3, 2'h2);
    grant(10'h341, 1'b1, 4'h8, 2'h3);
    // nesting
    grant(10'h008, 1'b1, 4'h3, 2'h2);
    core.take(0);
    rd(piw_pkg::OFS_SERVICE, 8'h04, "in service");
    grant(10'h040, 1'b0, 4'h0, 2'h0);
    grant(10'h001, 1'b0, 4'h0, 2'h0);
    grant(10'h100, 1'b1, 4'h8, 2'h3);
    core.take(3);
    rd(piw_pkg::OFS_SERVICE, 8'h0c, "nested");
    rd(piw_pkg::OFS_STAT, 8'h05, "status");
    grant(10'h200, 1'b0, 4'h0, 2'h0);
    core.ret();
    rd(piw_pkg::OFS_SERVICE, 8'h04, "return");
    grant(10'h200, 1'b1, 4'h9, 2'h3);
    core.ret();
    rd(piw_pkg::OFS_SERVICE, 8'h80, "second return");
    // first source joins the top-level tie and wins it
    lv[0] = 2'h3;
    set_prio();
    grant(10'h301, 1'b1, 4'h0, 2'h3);
    // interrupt line: mask, raise, clear
    chk({7'h00, irq}, 8'h00, "irq masked");
    wr(piw_pkg::OFS_MASK, 8'h01);
    chk({7'h00, irq}, 8'h01, "irq raised");
    wr(piw_pkg::OFS_STAT, 8'h01);
    chk({7'h00, irq}, 8'h00, "irq cleared");
    rd(piw_pkg::OFS_STAT, 8'h04, "one bit cleared");
    // wake from idle and power-down
    set_en(1'b1, 10'h081);
    @(posedge clk);
    src_req <= 10'h001;
    core_idle <= 1'b1;
    tick(2);
    chk({7'h00, wake}, 8'h01, "idle wake");
    rd(piw_pkg::OFS_STAT, 8'h06, "wake event");
    @(posedge clk);
    core_idle <= 1'b0;
    core_pd <= 1'b1;
    tick(2);
    chk({7'h00, wake}, 8'h00, "timer in power-down");
    @(posedge clk);
    src_req <= 10'h080;
    tick(2);
    chk({7'h00, wake}, 8'h01, "keypad wake");
    set_en(1'b1, 10'h001);
    tick(2);
    chk({7'h00, wake}, 8'h00, "keypad disabled");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
